/* File: rtl/ar_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module ar_timer
  import ar_timer_pkg::*;
#(
  parameter int PRESCALE_W = 7
)(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ar_timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_input_pin,
  output logic timer_output_pin,
  output ar_timer_pkg::irq_req_t irq_req
);
  import ar_timer_pkg::*;

  logic [7:0] mode_register_reg;
  logic [2:0] flag_register_reg;
  logic [7:0] clock_edge_register_reg;
  logic [7:0] reload_capture_value_reg;
  logic [7:0] compare_value_reg;
  logic [7:0] main_counter_reg;
  logic [PRESCALE_W-1:0] prescaler_count_reg;
  logic [1:0] div3_reg;
  logic [2:0] pin_sync_reg;
  logic pin_level_reg;
  logic wave_reg;
  logic [31:0] prdata_reg;

  logic wr_en;
  logic rd_en;
  logic addr_hit;
  logic [7:0] reg_index;
  logic [7:0] wbyte;
  op_mode_t op_mode;
  clk_src_t clk_src;
  logic [2:0] prescale_select;
  logic count_clock_enable;
  logic wave_output_enable;
  logic edge_enable;
  logic edge_falling;
  logic pin_new;
  logic pin_changed;
  logic pin_rise;
  logic pin_fall;
  logic active_edge;
  logic src_tick;
  logic pre_tick;
  logic count_tick;
  logic wrap_event;
  logic match_event;
  logic capture_event;
  logic ext_load_event;
  logic counter_load_strobe;
  logic load_reg_write;
  logic counter_reload;
  logic [PRESCALE_W-1:0] pre_mask;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign reg_index = paddr[9:2];
  assign addr_hit = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0) &&
                    (reg_index == IDX_MODE || reg_index == IDX_FLAGS ||
                     reg_index == IDX_CLKEDGE || reg_index == IDX_RELOAD ||
                     reg_index == IDX_COMPARE || reg_index == IDX_LOAD);
  assign wbyte = pwdata[7:0];
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = prdata_reg;

  assign op_mode = op_mode_t'(mode_register_reg[MODE_SEL_LSB +: 2]);
  assign count_clock_enable = mode_register_reg[MODE_EN_BIT];
  assign wave_output_enable = mode_register_reg[MODE_WAVE_OUTPUT_ENABLE_BIT];
  assign clk_src = clk_src_t'(clock_edge_register_reg[CC_LSB +: 2]);
  assign prescale_select = clock_edge_register_reg[PS_LSB +: 3];
  assign edge_enable = clock_edge_register_reg[SL_LSB];
  assign edge_falling = clock_edge_register_reg[SL_LSB+1];

  // pin passes three flops; a change counts once stages two and three agree
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      pin_sync_reg <= 3'h0;
    else
      pin_sync_reg <= {pin_sync_reg[1:0], timer_input_pin};
  end

  assign pin_new = pin_sync_reg[2];
  assign pin_changed = (pin_sync_reg[2] == pin_sync_reg[1]) && (pin_new != pin_level_reg);

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      pin_level_reg <= 1'b0;
    else if (pin_changed)
      pin_level_reg <= pin_new;
  end

  assign pin_rise = pin_changed && pin_new;
  assign pin_fall = pin_changed && !pin_new;
  assign active_edge = edge_enable && (edge_falling ? pin_fall : pin_rise);

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      div3_reg <= 2'h0;
    else if (div3_reg == FINT_DIV)
      div3_reg <= 2'h0;
    else
      div3_reg <= div3_reg + 2'h1;
  end

  // clock source select; reserved code gives no ticks
  always_comb
  begin
    src_tick = 1'b0;
    unique case (clk_src)
      CLK_INT: src_tick = 1'b1;
      CLK_INT_DIV3: src_tick = (div3_reg == FINT_DIV);
      CLK_PIN: src_tick = pin_rise;
      CLK_RSVD: src_tick = 1'b0;
    endcase
  end

  // ratio of 2**select: tick when the low bits are all ones
  assign pre_mask = PRESCALE_W'((8'h01 << prescale_select) - 8'h01);
  assign pre_tick = src_tick && ((prescaler_count_reg & pre_mask) == pre_mask);
  assign count_tick = count_clock_enable && pre_tick;

  assign load_reg_write = wr_en && addr_hit && reg_index == IDX_LOAD;
  assign counter_load_strobe = wr_en && addr_hit && reg_index == IDX_MODE &&
                               wbyte[MODE_LOAD_BIT];
  assign wrap_event = count_tick && main_counter_reg == 8'hFF;
  assign match_event = main_counter_reg == compare_value_reg &&
                       count_clock_enable && pre_tick;
  assign capture_event = active_edge &&
                         (op_mode == MODE_CAPTURE || op_mode == MODE_CAPTURE_RESET);
  assign ext_load_event = active_edge && op_mode == MODE_EXT_LOAD;
  assign counter_reload = counter_load_strobe || ext_load_event || wrap_event;

  // any counter load restarts the prescaler
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      prescaler_count_reg <= '0;
    else if (counter_reload || load_reg_write ||
             (capture_event && op_mode == MODE_CAPTURE_RESET))
      prescaler_count_reg <= '0;
    else if (count_clock_enable && src_tick)
      prescaler_count_reg <= pre_tick ? '0 : prescaler_count_reg + 1'b1;
  end

  // counter priority: software load beats hardware events
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      main_counter_reg <= 8'h00;
    else if (load_reg_write)
      main_counter_reg <= wbyte;
    else if (counter_load_strobe || ext_load_event)
      main_counter_reg <= reload_capture_value_reg;
    else if (capture_event && op_mode == MODE_CAPTURE_RESET)
      main_counter_reg <= 8'h00;
    else if (wrap_event)
      main_counter_reg <= reload_capture_value_reg;
    else if (count_tick)
      main_counter_reg <= main_counter_reg + 8'h01;
  end

  // reset clears mode register; load bit not kept
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      mode_register_reg <= MODE_RESET;
    else if (wr_en && addr_hit && reg_index == IDX_MODE)
      mode_register_reg <= {1'b0, wbyte[6:0]};
  end

  // reserved bit kept zero regardless of what software writes
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      clock_edge_register_reg <= CLKEDGE_RESET;
    else if (wr_en && addr_hit && reg_index == IDX_CLKEDGE)
      clock_edge_register_reg <= wbyte & CLKEDGE_WMASK;
  end

  // capture copies counter; software write loses to capture
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      reload_capture_value_reg <= 8'h00;
    else if (capture_event)
      reload_capture_value_reg <= main_counter_reg;
    else if (wr_en && addr_hit && reg_index == IDX_RELOAD)
      reload_capture_value_reg <= wbyte;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      compare_value_reg <= 8'h00;
    else if (wr_en && addr_hit && reg_index == IDX_COMPARE)
      compare_value_reg <= wbyte;
  end

  // write zero clears, one keeps; a new event wins over the clear
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      flag_register_reg <= 3'h0;
    else
    begin
      if (wr_en && addr_hit && reg_index == IDX_FLAGS)
        flag_register_reg <= flag_register_reg & wbyte[2:0] |
                             {active_edge, match_event, wrap_event};
      else
        // edge flag on every active edge
        flag_register_reg <= flag_register_reg |
                             {active_edge, match_event, wrap_event};
    end
  end

  // overflow sets wave, match clears; match wins on the same tick
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      wave_reg <= 1'b0;
    else if (match_event)
      wave_reg <= 1'b0;
    else if (wrap_event)
      wave_reg <= 1'b1;
  end

  assign timer_output_pin = wave_reg && wave_output_enable;

  assign irq_req.edge_irq = flag_register_reg[FLAG_EDGE_BIT] && mode_register_reg[MODE_EIE_BIT];
  assign irq_req.match_irq = flag_register_reg[FLAG_MATCH_BIT] &&
                             mode_register_reg[MODE_MATCH_IRQ_ENABLE_BIT];
  assign irq_req.wrap_irq = flag_register_reg[FLAG_WRAP_BIT] && mode_register_reg[MODE_WRAP_IRQ_ENABLE_BIT];

  // read data registered in the setup cycle; the bus samples it in the access cycle
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      prdata_reg <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      prdata_reg <= 32'h0;
      case (paddr[9:2])
        IDX_MODE: prdata_reg[7:0] <= {1'b0, mode_register_reg[6:0]};
        IDX_FLAGS: prdata_reg[2:0] <= flag_register_reg;
        IDX_CLKEDGE: prdata_reg[7:0] <= clock_edge_register_reg;
        IDX_RELOAD: prdata_reg[7:0] <= reload_capture_value_reg;
        IDX_COMPARE: prdata_reg[7:0] <= compare_value_reg;
        // live value; no stored reset state exists
        IDX_LOAD: prdata_reg[7:0] <= main_counter_reg;
        default: prdata_reg <= 32'h0;
      endcase
    end
  end

endmodule : ar_timer

`default_nettype wire

/* File: rtl/ar_timer_pkg.sv */
package ar_timer_pkg;

  // printed offsets are not all multiples of four: they are register indices
  localparam logic [7:0] IDX_MODE = 8'hE5;
  localparam logic [7:0] IDX_FLAGS = 8'hE6;
  localparam logic [7:0] IDX_CLKEDGE = 8'hE7;
  localparam logic [7:0] IDX_RELOAD = 8'hE9;
  localparam logic [7:0] IDX_COMPARE = 8'hEA;
  localparam logic [7:0] IDX_LOAD = 8'hEB;
  localparam int ADDR_W = 12;

  // mode register fields
  localparam int MODE_LOAD_BIT = 7;
  localparam int MODE_EN_BIT = 6;
  localparam int MODE_WAVE_OUTPUT_ENABLE_BIT = 5;
  localparam int MODE_EIE_BIT = 4;
  localparam int MODE_MATCH_IRQ_ENABLE_BIT = 3;
  localparam int MODE_WRAP_IRQ_ENABLE_BIT = 2;
  localparam int MODE_SEL_LSB = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // flag register fields
  localparam int FLAG_EDGE_BIT = 2;
  localparam int FLAG_MATCH_BIT = 1;
  localparam int FLAG_WRAP_BIT = 0;

  // clock/edge/prescale register fields
  localparam int PS_LSB = 5;
  localparam int SL_LSB = 2;
  localparam int CC_LSB = 0;
  localparam logic [7:0] CLKEDGE_RESET = 8'h00;
  localparam logic [7:0] CLKEDGE_WMASK = 8'hEF;

  localparam logic [1:0] FINT_DIV = 2'h2;

  typedef enum logic [1:0] {
    MODE_AUTO_RELOAD = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_CAPTURE_RESET = 2'b10,
    MODE_EXT_LOAD = 2'b11
  } op_mode_t;

  typedef enum logic [1:0] {
    CLK_INT = 2'b00,
    CLK_INT_DIV3 = 2'b01,
    CLK_PIN = 2'b10,
    CLK_RSVD = 2'b11
  } clk_src_t;

  typedef struct packed {
    logic edge_irq;
    logic match_irq;
    logic wrap_irq;
  } irq_req_t;

endpackage : ar_timer_pkg

/* File: sim/ext_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none

// far-side pin: level changes one edge after the request, never mid-cycle
module ext_pin_model (
  input wire logic ref_clk,
  input wire logic drive_level,
  output logic pin
);
  initial pin = 1'b0;
  // plain always: the initial value above would be a second driver under always_ff
  always @(posedge ref_clk)
    pin <= drive_level;
endmodule : ext_pin_model

`default_nettype wire

/* File: sim/ar_timer_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module ar_timer_sva
  import ar_timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ar_timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_input_pin,
  input wire logic timer_output_pin,
  input wire ar_timer_pkg::irq_req_t irq_req
);
  logic [7:0] mode_reg;
  logic acc;
  logic mapped;
  assign acc = psel && penable;
  assign mapped = paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00 && (paddr[9:2] inside
    {IDX_MODE, IDX_FLAGS, IDX_CLKEDGE, IDX_RELOAD, IDX_COMPARE, IDX_LOAD});
  // shadow of the enables; the load strobe is never kept
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      mode_reg <= MODE_RESET;
    else if (acc && pwrite && paddr == {2'b00, IDX_MODE, 2'b00})
      mode_reg <= {1'b0, pwdata[6:0]};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  zero_wait_a: assert property (acc |-> pready) else $error("pready late");
  bad_addr_a: assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong");
  load_bit_a: assert property (acc && !pwrite && paddr == {2'b00, IDX_MODE, 2'b00}
    |-> prdata[7:0] == mode_reg) else $error("mode read wrong");
  freeze_a: assert property (!mode_reg[6] && !$past(mode_reg[6]) && !psel
    |=> !$rose(irq_req.wrap_irq) && !$rose(irq_req.match_irq)) else $error("counted");
  wave_gate_a: assert property (!mode_reg[5] |-> !timer_output_pin)
    else $error("pwm not gated");
  edge_mask_a: assert property (irq_req.edge_irq |-> mode_reg[4]) else $error("edge mask");
  match_mask_a: assert property (irq_req.match_irq |-> mode_reg[3]) else $error("match mask");
  wrap_mask_a: assert property (irq_req.wrap_irq |-> mode_reg[2]) else $error("wrap mask");
  reset_quiet_a: assert property ($fell(reset) |-> irq_req == 3'b000
    && !timer_output_pin) else $error("not quiet after reset");
endmodule : ar_timer_sva

bind ar_timer ar_timer_sva u_sva (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .timer_input_pin, .timer_output_pin, .irq_req);

`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  import ar_timer_pkg::*;
  logic ref_clk, reset, psel, penable, pwrite, drive_level;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, timer_input_pin, timer_output_pin;
  irq_req_t irq_req;
  int n_mismatch, cmp_count;
  logic [7:0] rd;

  ar_timer dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer_input_pin, .timer_output_pin, .irq_req);
  ext_pin_model u_pin (.ref_clk, .drive_level, .pin(timer_input_pin));

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task chk(input string w, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task chb(input string w, input logic e, input logic g);
    chk(w, {7'h00, e}, {7'h00, g});
  endtask : chb

  // one full setup/access cycle, then an idle edge so psel is never re-driven at once
  task xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50)
      n_mismatch++;
    q = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : xfer

  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, idx, d, q);
  endtask : wr

  task rdc(input string w, input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] q;
    xfer(1'b0, idx, 8'h00, q);
    chk(w, e, q);
  endtask : rdc

  task wait_irq(input int b);
    int n;
    n = 0;
    while (irq_req[b] !== 1'b1 && n < 400)
    begin
      @(posedge ref_clk);
      n++;
    end
    chb("irq", 1'b1, irq_req[b]);
  endtask : wait_irq

  task pin(input logic v);
    drive_level <= v;
    repeat (10) @(posedge ref_clk);
  endtask : pin

  initial
  begin
    reset = 1'b1;
    {psel, penable, pwrite, drive_level} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rdc("mode", IDX_MODE, 8'h00);
    wr(IDX_CLKEDGE, 8'h10);
    rdc("clkedge", IDX_CLKEDGE, 8'h00);
    wr(IDX_RELOAD, 8'hF0);
    wr(IDX_COMPARE, 8'hF8);
    wr(IDX_MODE, 8'hEC);
    rdc("mode", IDX_MODE, 8'h6C);
    wait_irq(1);
    wait_irq(0);
    repeat (2) @(posedge ref_clk);
    chb("pwm", 1'b1, timer_output_pin);
    wr(IDX_MODE, 8'h0C);
    chb("pwm off", 1'b0, timer_output_pin);
    wr(IDX_FLAGS, 8'hFF);
    rdc("flags", IDX_FLAGS, 8'h03);
    wr(IDX_FLAGS, 8'h02);
    rdc("flags", IDX_FLAGS, 8'h02);
    chk("irq", 8'h02, {5'h00, irq_req});
    wr(IDX_MODE, 8'h04);
    chb("match irq", 1'b0, irq_req.match_irq);
    wr(IDX_FLAGS, 8'h00);
    rdc("flags", IDX_FLAGS, 8'h00);
    xfer(1'b0, IDX_LOAD, 8'h00, rd);
    repeat (20) @(posedge ref_clk);
    rdc("frozen", IDX_LOAD, rd);
    wr(IDX_CLKEDGE, 8'hE0);
    wr(IDX_LOAD, 8'h10);
    wr(IDX_MODE, 8'h40);
    rdc("slow", IDX_LOAD, 8'h10);
    repeat (300) @(posedge ref_clk);
    rdc("slow", IDX_LOAD, 8'h12);
    wr(IDX_MODE, 8'h00);
    wr(IDX_LOAD, 8'h20);
    rdc("live", IDX_LOAD, 8'h20);
    wr(IDX_MODE, 8'h11);
    wr(IDX_CLKEDGE, 8'h04);
    pin(1'b1);
    wait_irq(2);
    rdc("capture", IDX_RELOAD, 8'h20);
    wr(IDX_FLAGS, 8'h00);
    wr(IDX_CLKEDGE, 8'h0C);
    pin(1'b0);
    wait_irq(2);
    wr(IDX_FLAGS, 8'h00);
    pin(1'b1);
    chb("rise ignored", 1'b0, irq_req.edge_irq);
    wr(IDX_CLKEDGE, 8'h08);
    pin(1'b0);
    chb("edge off", 1'b0, irq_req.edge_irq);
    wr(IDX_MODE, 8'h02);
    wr(IDX_CLKEDGE, 8'h04);
    pin(1'b1);
    rdc("cap reset", IDX_LOAD, 8'h00);
    wr(IDX_RELOAD, 8'h33);
    wr(IDX_MODE, 8'h03);
    pin(1'b0);
    pin(1'b1);
    rdc("ext load", IDX_LOAD, 8'h33);
    wr(IDX_MODE, 8'h00);
    wr(IDX_CLKEDGE, 8'h02);
    wr(IDX_LOAD, 8'h00);
    wr(IDX_MODE, 8'h40);
    pin(1'b0);
    pin(1'b1);
    pin(1'b0);
    pin(1'b1);
    rdc("pin clock", IDX_LOAD, 8'h02);
    rdc("unmapped", 8'hE8, 8'h00);
    end_of_test;
  end

  initial
  begin
    #200000;
    n_mismatch++;
    end_of_test;
  end
endmodule : tb

`default_nettype wire
